// ### rtl/asds_pkg.sv
// Purpose: constants and types for the speed and duplex selection block
// Assumes: apb with 32-bit data, word aligned registers
// Notes: reset values and offsets live here only
// Overview of operation
// - check partner negotiation capable bit 3
// - advertise local abilities from advertisement register
// - store partner abilities for software reads
// - resolve mode by standard priority order
// - apply resolved speed, duplex, start link check
// - negotiate only when both enables are set
// - mac enable low uses mac speed, duplex
// - mac high, phy low uses phy bits
// - speed one is 100, duplex one is full
// - mac negotiation enable resets to zero
// - reset gives isolation, manual, 10, half
// - restart on link fail, reset or enable
package asds_pkg;
    // register byte addresses; the mac control register is word index 0xa, its byte address four times that
    localparam logic [11:0] asds_ctrl_idx = 12'h000a;
    localparam logic [11:0] asds_rxphy_addr = {asds_ctrl_idx[9:0], 2'b00};
    localparam logic [11:0] asds_phy0_addr = 12'h0000;
    localparam logic [11:0] asds_adv_addr = 12'h0010;
    localparam logic [11:0] asds_remote_addr = 12'h0014;
    localparam logic [11:0] asds_status_addr = 12'h0048;
    localparam logic [11:0] asds_txctl_addr = 12'h004c;
    // field positions in receive_phy_control
    localparam int asds_rxphy_speed = 13;
    localparam int asds_rxphy_duplex = 12;
    localparam int asds_rxphy_neg = 11;
    // field positions in the phy control word
    localparam int asds_p0_reset = 15;
    localparam int asds_p0_speed = 13;
    localparam int asds_p0_neg = 12;
    localparam int asds_p0_isolate = 10;
    localparam int asds_p0_restart = 9;
    localparam int asds_p0_duplex = 8;
    // partner capable bit of partner status
    localparam int asds_partner_capable_bit = 3;
    // reset values
    localparam logic [15:0] asds_rxphy_reset = 16'h0000;
    localparam logic [15:0] asds_phy0_reset = 16'h0400;
    localparam logic [3:0] asds_adv_reset = 4'hf;
    // time allowed for one negotiation exchange
    localparam int asds_neg_time_ns = 1000;
    localparam int asds_clock_ns = 4;
    localparam int asds_neg_cycles = asds_neg_time_ns / asds_clock_ns;
    // resolved mode, ability order: fast full, fast half, slow full, slow half
    typedef enum logic [3:0] {
        asds_mode_ff = 4'b1000,
        asds_mode_fh = 4'b0100,
        asds_mode_sf = 4'b0010,
        asds_mode_sh = 4'b0001
    } asds_mode_t;
    // negotiation states
    typedef enum logic [3:0] {
        asds_st_idle = 4'b0001,
        asds_st_sense = 4'b0010,
        asds_st_exchange = 4'b0100,
        asds_st_done = 4'b1000
    } asds_state_t;
endpackage : asds_pkg

// ### rtl/asds_sync.sv
// Purpose: three flop synchroniser with agreement filter
// Assumes: input from outside the clock domain
// Notes: first flop feeds only the second
module asds_sync #(
    parameter int width = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] stage1; // metastable catch
    logic [width-1:0] stage2;
    logic [width-1:0] stage3;
    // shift chain; output moves only when stages two and three agree
    always_ff @(posedge clock) begin
        if (reset) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= (stage2 & stage3) | (sync_out & (stage2 | stage3));
        end
    end
endmodule : asds_sync

// ### rtl/asds_resolve.sv
// Purpose: priority resolution of common abilities
// Assumes: ability order fast full, fast half, slow full, slow half
// Notes: registered result, no common ability gives valid low
module asds_resolve
    import asds_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] local_abil,
    input wire logic [3:0] partner_abil,
    output asds_mode_t mode,
    output logic valid
);
    logic [3:0] common; // abilities shared by both ends
    assign common = local_abil & partner_abil;
    always_ff @(posedge clock) begin
        if (reset) begin
            mode <= asds_mode_sh;
            valid <= 1'b0;
        end else begin
            valid <= |common;
            if (common[3]) begin
                mode <= asds_mode_ff;
            end else if (common[2]) begin
                mode <= asds_mode_fh;
            end else if (common[1]) begin
                mode <= asds_mode_sf;
            end else begin
                mode <= asds_mode_sh;
            end
        end
    end
endmodule : asds_resolve

// ### rtl/asds_top.sv
// Purpose: speed and duplex selection with negotiation, apb registers
// Assumes: partner abilities and status arrive as pin levels
// Notes: zero wait apb; unmapped reads return zero, pslverr low
//
// Chosen here: register access over APB.
module asds_top
    import asds_pkg::*;
#(
    parameter int neg_cycles = asds_neg_cycles
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] partner_status,
    input wire logic [3:0] partner_abilities,
    input wire logic partner_abil_valid,
    input wire logic link_ok,
    output logic [3:0] advertise_out,
    output logic advertise_send,
    output logic speed_100,
    output logic full_duplex,
    output logic link_check_fast,
    output logic link_check_start,
    output logic isolate,
    output logic mac_full_duplex_select
);
    import asds_pkg::*;

    logic [15:0] receive_phy_control; // mac side control
    logic [15:0] phy_control; // phy control word
    logic [3:0] adv; // advertise_fast_full..advertise_slow_half
    logic [3:0] remote_abil; // stored partner abilities
    logic neg_complete;
    asds_state_t state;
    asds_state_t next_state;
    logic [31:0] timer;
    logic [15:0] p_status_s;
    logic [3:0] p_abil_s;
    logic p_valid_s;
    logic link_ok_s;
    logic link_ok_d;
    logic neg_on;
    logic neg_on_d;
    logic restart_req;
    logic wr_en;
    logic rd_en;
    asds_mode_t res_mode;
    logic res_valid;
    logic mac_negotiation_enable;
    logic phy_negotiation_enable;

    // pin inputs from the partner side cross in through filters
    asds_sync #(.width(16)) u_sync_status (.clock(clock), .reset(reset),
        .async_in(partner_status), .sync_out(p_status_s));
    asds_sync #(.width(4)) u_sync_abil (.clock(clock), .reset(reset),
        .async_in(partner_abilities), .sync_out(p_abil_s));
    asds_sync #(.width(2)) u_sync_ctl (.clock(clock), .reset(reset),
        .async_in({partner_abil_valid, link_ok}), .sync_out({p_valid_s, link_ok_s}));

    asds_resolve u_resolve (.clock(clock), .reset(reset), .local_abil(adv),
        .partner_abil(remote_abil), .mode(res_mode), .valid(res_valid));

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1; // every access completes in its first access cycle
    assign pslverr = 1'b0;
    assign mac_negotiation_enable = receive_phy_control[asds_rxphy_neg];
    assign phy_negotiation_enable = phy_control[asds_p0_neg];
    assign neg_on = mac_negotiation_enable & phy_negotiation_enable;
    assign isolate = phy_control[asds_p0_isolate];

    // mac side control register
    // enable resets low
    always_ff @(posedge clock) begin
        if (reset) begin
            receive_phy_control <= asds_rxphy_reset;
        end else if (wr_en && paddr == asds_rxphy_addr) begin
            receive_phy_control <= pwdata[15:0];
        end
    end

    // phy control word; reset and restart bits self clear
    // isolated manual start
    always_ff @(posedge clock) begin
        if (reset) begin
            phy_control <= asds_phy0_reset;
        end else if (wr_en && paddr == asds_phy0_addr) begin
            phy_control <= pwdata[15:0];
        end else if (phy_control[asds_p0_reset]) begin
            phy_control <= asds_phy0_reset;
        end else begin
            phy_control[asds_p0_restart] <= 1'b0;
        end
    end

    // advertisement and mac duplex select written by software
    always_ff @(posedge clock) begin
        if (reset) begin
            adv <= asds_adv_reset;
            mac_full_duplex_select <= 1'b0;
        end else if (wr_en && paddr == asds_adv_addr) begin
            adv <= pwdata[3:0];
        end else if (wr_en && paddr == asds_txctl_addr) begin
            mac_full_duplex_select <= pwdata[0];
        end
    end

    // restart on link loss, reset, restart bit or fresh enable
    always_ff @(posedge clock) begin
        if (reset) begin
            link_ok_d <= 1'b0;
            neg_on_d <= 1'b0;
        end else begin
            link_ok_d <= link_ok_s;
            neg_on_d <= neg_on;
        end
    end
    assign restart_req = (link_ok_d & ~link_ok_s) | (neg_on & ~neg_on_d)
        | phy_control[asds_p0_restart] | phy_control[asds_p0_reset];

    // negotiation sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            asds_st_idle: begin
                if (neg_on) begin
                    next_state = asds_st_sense;
                end
            end
            asds_st_sense: begin
                if (p_status_s[asds_partner_capable_bit]) begin
                    next_state = asds_st_exchange;
                end
            end
            asds_st_exchange: begin
                if (p_valid_s && res_valid && timer == 32'h0000_0000) begin
                    next_state = asds_st_done;
                end
            end
            asds_st_done: begin
                next_state = asds_st_done;
            end
        endcase
        if (!neg_on) begin
            next_state = asds_st_idle;
        end else if (restart_req) begin
            next_state = asds_st_sense;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= asds_st_idle;
        end else begin
            state <= next_state;
        end
    end

    // exchange pacing timer
    always_ff @(posedge clock) begin
        if (reset || state != asds_st_exchange) begin
            timer <= 32'(neg_cycles - 1);
        end else if (timer != 32'h0000_0000) begin
            timer <= timer - 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            advertise_send <= 1'b0;
            advertise_out <= 4'h0;
        end else begin
            advertise_send <= (state == asds_st_exchange) && !isolate;
            advertise_out <= adv;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            remote_abil <= 4'h0;
        end else if (state == asds_st_sense) begin
            // forget the last partner so resolution never runs on stale abilities
            remote_abil <= 4'h0;
        end else if (state == asds_st_exchange && p_valid_s) begin
            remote_abil <= p_abil_s;
        end
    end

    // operating mode selection and link check start
    always_ff @(posedge clock) begin
        if (reset) begin
            speed_100 <= 1'b0;
            full_duplex <= 1'b0;
            neg_complete <= 1'b0;
            link_check_start <= 1'b0;
        end else begin
            link_check_start <= 1'b0;
            neg_complete <= (next_state == asds_st_done);
            if (!mac_negotiation_enable) begin
                speed_100 <= receive_phy_control[asds_rxphy_speed];
                full_duplex <= receive_phy_control[asds_rxphy_duplex];
            end else if (!phy_negotiation_enable) begin
                speed_100 <= phy_control[asds_p0_speed];
                full_duplex <= phy_control[asds_p0_duplex];
            end else if (state == asds_st_exchange && next_state == asds_st_done) begin
                speed_100 <= res_mode inside {asds_mode_ff, asds_mode_fh};
                full_duplex <= res_mode inside {asds_mode_ff, asds_mode_sf};
                link_check_start <= 1'b1;
            end
        end
    end
    assign link_check_fast = speed_100; // picks 100 or 10 link integrity

    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                asds_rxphy_addr: prdata <= {16'h0000, receive_phy_control};
                asds_phy0_addr: prdata <= {16'h0000, phy_control};
                asds_adv_addr: prdata <= {28'h000_0000, adv};
                asds_remote_addr: prdata <= {28'h000_0000, remote_abil};
                asds_status_addr: prdata <= {29'h0000_0000, neg_complete, speed_100, full_duplex};
                asds_txctl_addr: prdata <= {31'h0000_0000, mac_full_duplex_select};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    a_manual_when_off: assert property (@(posedge clock) disable iff (reset)
        !neg_on |=> state == asds_st_idle)
        else $error("negotiation ran with an enable low");
    a_mac_bits_used: assert property (@(posedge clock) disable iff (reset)
        !mac_negotiation_enable |=> speed_100 == $past(receive_phy_control[asds_rxphy_speed]))
        else $error("mac speed bit not applied");
    a_phy_bits_used: assert property (@(posedge clock) disable iff (reset)
        mac_negotiation_enable && !phy_negotiation_enable |=> full_duplex == $past(phy_control[asds_p0_duplex]))
        else $error("phy duplex bit not applied");
    a_capable_check: assert property (@(posedge clock) disable iff (reset)
        state == asds_st_sense && !p_status_s[asds_partner_capable_bit] && !restart_req && neg_on
        |=> state == asds_st_sense)
        else $error("left sense without capable partner");
    a_link_fail_restart: assert property (@(posedge clock) disable iff (reset)
        neg_on && link_ok_d && !link_ok_s |=> state == asds_st_sense)
        else $error("link fail did not restart");
    a_done_link_check: assert property (@(posedge clock) disable iff (reset)
        neg_on && state == asds_st_exchange && next_state == asds_st_done |=> link_check_start && neg_complete)
        else $error("completion did not start link check");
    a_adv_send_state: assert property (@(posedge clock) disable iff (reset)
        advertise_send |-> $past(state) == asds_st_exchange)
        else $error("advertising outside exchange");
    a_reset_isolated: assert property (@(posedge clock)
        $past(reset) && !reset |-> isolate && !speed_100 && !full_duplex && !mac_negotiation_enable)
        else $error("reset state wrong");
    a_mac_duplex_used: assert property (@(posedge clock) disable iff (reset)
        !mac_negotiation_enable |=> full_duplex == $past(receive_phy_control[asds_rxphy_duplex]))
        else $error("mac duplex bit not applied");
    a_remote_store: assert property (@(posedge clock) disable iff (reset)
        state == asds_st_exchange && p_valid_s |=> remote_abil == $past(p_abil_s))
        else $error("partner abilities not stored");
    a_priority_top: assert property (@(posedge clock) disable iff (reset)
        $past(adv[3] && remote_abil[3]) |-> res_mode == asds_mode_ff)
        else $error("fast full not chosen");
    a_priority_half: assert property (@(posedge clock) disable iff (reset)
        $past(adv[3:2] & remote_abil[3:2]) == 2'b01 |-> res_mode == asds_mode_fh)
        else $error("fast half not chosen");
    a_complete_status: assert property (@(posedge clock) disable iff (reset)
        neg_on && state == asds_st_done && !restart_req |=> neg_complete)
        else $error("completion status missing");
    a_adv_content: assert property (@(posedge clock) disable iff (reset)
        advertise_send |-> advertise_out == $past(adv))
        else $error("advertised word differs from register");
    a_restart_bit: assert property (@(posedge clock) disable iff (reset)
        neg_on && phy_control[asds_p0_restart] |=> state == asds_st_sense)
        else $error("restart bit did not restart");
endmodule : asds_top

// ### testbench/asds_partner.sv
// Purpose: remote link partner model on the negotiation pins
// Assumes: partner abilities become valid some cycles after local pulses start
// Notes: invalid abilities toggle every cycle, so a stale value cannot pass for a real one
module asds_partner (
    input wire logic clock,
    input wire logic reset,
    input wire logic capable, // partner can negotiate
    input wire logic [3:0] abil, // abilities the partner offers
    input wire logic link_up, // cable state
    input wire logic [7:0] delay, // pulse cycles before abilities appear
    input wire logic advertise_send,
    input wire logic [3:0] advertise_out,
    output logic [15:0] partner_status,
    output logic [3:0] partner_abilities,
    output logic partner_abil_valid,
    output logic link_ok,
    output logic [3:0] heard // last advertisement seen during pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] burst; // pulse cycles heard so far
    logic [3:0] junk; // filler while abilities are not valid
    assign partner_status = {12'h000, capable, 3'b000};
    assign link_ok = link_up;
    // count pulse cycles; a slow partner answers only after the delay
    always_ff @(posedge clock) begin
        if (reset || !advertise_send) begin
            burst <= 8'h00;
        end else if (burst != 8'hff) begin
            burst <= burst + 8'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            junk <= 4'h5;
            heard <= 4'h0;
        end else begin
            junk <= ~junk;
            if (advertise_send) begin
                heard <= advertise_out;
            end
        end
    end
    assign partner_abil_valid = advertise_send && (burst >= delay);
    assign partner_abilities = partner_abil_valid ? abil : junk;
endmodule : asds_partner

// ### testbench/tb.sv
// Purpose: self-checking bench for speed and duplex selection
// Assumes: zero wait apb; negotiation time shortened to 4 cycles
// Notes: the partner model drives every link pin, so no design input is tied
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import asds_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic capable = 1'b1; // partner model settings
    logic [3:0] abil = 4'hf;
    logic link_up = 1'b1;
    logic [7:0] delay = 8'h00;
    logic [15:0] partner_status;
    logic [3:0] partner_abilities;
    logic partner_abil_valid;
    logic link_ok;
    logic [3:0] heard;
    logic [3:0] advertise_out;
    logic advertise_send;
    logic speed_100;
    logic full_duplex;
    logic link_check_fast;
    logic link_check_start;
    logic isolate;
    logic mac_full_duplex_select;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    // negotiation table: local advertisement, partner offer, {speed, duplex}
    logic [3:0] t_adv [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'hf};
    logic [3:0] t_pab [5] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h5};
    logic [1:0] t_sd [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2};

    asds_top #(.neg_cycles(4)) i_asds_top (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .partner_status(partner_status), .partner_abilities(partner_abilities),
        .partner_abil_valid(partner_abil_valid), .link_ok(link_ok), .advertise_out(advertise_out),
        .advertise_send(advertise_send), .speed_100(speed_100), .full_duplex(full_duplex),
        .link_check_fast(link_check_fast), .link_check_start(link_check_start), .isolate(isolate),
        .mac_full_duplex_select(mac_full_duplex_select));
    asds_partner i_asds_partner (.clock(clock), .reset(reset), .capable(capable), .abil(abil),
        .link_up(link_up), .delay(delay), .advertise_send(advertise_send), .advertise_out(advertise_out),
        .partner_status(partner_status), .partner_abilities(partner_abilities),
        .partner_abil_valid(partner_abil_valid), .link_ok(link_ok), .heard(heard));

    // 250 MHz clock
    always #2 clock = ~clock;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one apb transfer: setup, then access held until pready at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(n, e & m, r & m);
    endtask : rd_chk

    // wait a bounded time for the completion pulse
    task automatic wait_done(input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clock);
            seen = (link_check_start === 1'b1);
        end
    endtask : wait_done

    // manual mode result at the pins and in status
    task automatic man_chk(input logic s, input logic d, input logic [31:0] m);
        repeat (2) @(posedge clock);
        chk("speed_100", 32'(s), 32'(speed_100));
        chk("full_duplex", 32'(d), 32'(full_duplex));
        chk("link_check_fast", 32'(s), 32'(link_check_fast));
        rd_chk("status", asds_status_addr, {29'h0000_0000, 1'b0, s, d}, m);
    endtask : man_chk

    // one negotiation from a fresh enable
    task automatic neg(input int k);
        logic seen;
        abil <= t_pab[k];
        delay <= (k % 2 == 1) ? 8'h14 : 8'h00;
        wr(asds_phy0_addr, 32'h0000_0000);
        wr(asds_adv_addr, 32'(t_adv[k]));
        wr(asds_phy0_addr, 32'h0000_1000);
        wait_done(400, seen);
        chk("negotiation done", 32'(1'b1), 32'(seen));
        chk("speed_100", 32'(t_sd[k][1]), 32'(speed_100));
        chk("full_duplex", 32'(t_sd[k][0]), 32'(full_duplex));
        chk("link_check_fast", 32'(t_sd[k][1]), 32'(link_check_fast));
        chk("advertised", 32'(t_adv[k]), 32'(heard));
        rd_chk("remote", asds_remote_addr, 32'(t_pab[k]), 32'h0000_000f);
        rd_chk("status", asds_status_addr, {29'h0000_0000, 1'b1, t_sd[k]}, 32'h0000_0007);
    endtask : neg

    initial begin
        logic s;
        logic d;
        logic seen;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        // values after reset
        rd_chk("mac control", asds_rxphy_addr, 32'(asds_rxphy_reset), 32'h0000_ffff);
        rd_chk("phy0", asds_phy0_addr, 32'h0000_0400, 32'h0000_ffff);
        rd_chk("adv", asds_adv_addr, 32'h0000_000f, 32'h0000_000f);
        rd_chk("txctl", asds_txctl_addr, 32'h0000_0000, 32'h0000_0001);
        chk("isolate", 32'(1'b1), 32'(isolate));
        chk("speed_100", 32'(1'b0), 32'(speed_100));
        chk("full_duplex", 32'(1'b0), 32'(full_duplex));
        wr(12'h0fc, 32'h0000_ffff);
        rd_chk("unmapped", 12'h0fc, 32'h0000_0000, 32'hffff_ffff);
        chk("pslverr", 32'h0000_0000, 32'(pslverr));
        // mac duplex select is plain software state
        wr(asds_txctl_addr, 32'h0000_0001);
        @(posedge clock);
        chk("mac_fdx", 32'(1'b1), 32'(mac_full_duplex_select));
        rd_chk("txctl", asds_txctl_addr, 32'h0000_0001, 32'h0000_0001);
        wr(asds_txctl_addr, 32'h0000_0000);
        @(posedge clock);
        chk("mac_fdx", 32'(1'b0), 32'(mac_full_duplex_select));
        // manual table; the ignored side always holds the opposite bits
        for (int i = 0; i < 4; i++) begin
            s = i[1];
            d = i[0];
            wr(asds_rxphy_addr, 32'({s, d, 12'h000}));
            wr(asds_phy0_addr, 32'({~s, 1'b1, 3'b000, ~d, 8'h00}));
            man_chk(s, d, 32'h0000_0007);
            chk("isolate", 32'(1'b0), 32'(isolate));
            chk("advertise_send", 32'(1'b0), 32'(advertise_send));
            wr(asds_phy0_addr, 32'({s, 1'b0, 3'b000, d, 8'h00}));
            wr(asds_rxphy_addr, 32'({~s, ~d, 1'b1, 11'h000}));
            man_chk(s, d, 32'h0000_0003);
        end
        // partner that cannot negotiate stalls negotiation in sense, before the exchange
        capable <= 1'b0;
        wr(asds_phy0_addr, 32'h0000_0000);
        wr(asds_rxphy_addr, 32'h0000_0800);
        wr(asds_phy0_addr, 32'h0000_1000);
        wait_done(60, seen);
        chk("incapable partner", 32'(1'b0), 32'(seen));
        capable <= 1'b1;
        wait_done(400, seen);
        chk("capable partner", 32'(1'b1), 32'(seen));
        for (int k = 0; k < 5; k++) begin
            neg(k);
        end
        // a link failure restarts negotiation
        link_up <= 1'b0;
        repeat (10) @(posedge clock);
        link_up <= 1'b1;
        wait_done(400, seen);
        chk("restart on link fail", 32'(1'b1), 32'(seen));
        // the self clearing restart bit reruns negotiation
        wr(asds_phy0_addr, 32'h0000_3200);
        wait_done(400, seen);
        chk("restart on restart bit", 32'(1'b1), 32'(seen));
        // the phy reset bit falls back to the isolated manual word
        wr(asds_phy0_addr, 32'h0000_8000);
        rd_chk("phy0 after reset", asds_phy0_addr, 32'h0000_0400, 32'h0000_ffff);
        chk("isolate", 32'(1'b1), 32'(isolate));
        stop_test();
    end
endmodule : tb
